//--- hdl/pio_port.sv
// Purpose: Parallel I/O port with edge latch and maskable interrupt
// Assumes: Plain register port, read data one cycle after read strobe
// Notes: Port mode, edge type and interrupt mode fixed at build time
//
// How it works
// - Width up to 32, every bit alike
// - Build as input, output or both
// - Bidirectional build shares one pin per bit
// - Host releases pins via direction register
// - Data read returns input port levels
// - Data write stores into output register
// - Read path never returns written value
// - Optional rising, falling or either edge detect
// - Qualifying edge sets its edge-latch bit
// - Edge type fixed, no register selects it
// - Optional interrupt request from input conditions
// - Direction 0 input, 1 output driving pin
// - Interrupt allowed only where mask bit set
// - Level: enabled input high; edge: enabled latch
// - Any write to edge latch clears all
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`include "pio_defines.svh"
`default_nettype none
module pio_port
  import pio_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter port_mode_type MODE = `PIO_MODE_INOUT,
  parameter bit HAS_EDGE = 1'b1,
  parameter edge_kind_type EDGE_KIND = `PIO_EDGE_RISE,
  parameter bit HAS_IRQ = 1'b1,
  parameter bit IRQ_EDGE = 1'b1,
  parameter logic [31:0] OUT_RESET = `PIO_OUT_RESET
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [`PIO_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [WIDTH-1:0] port_in,
  output logic [WIDTH-1:0] port_out,
  output logic [WIDTH-1:0] port_oe,
  output logic irq,
  output logic event_irq
);
  localparam bit HAS_IN = (MODE != `PIO_MODE_OUT);
  localparam bit HAS_OUT = (MODE != `PIO_MODE_IN);
  localparam bit BIDIR = (MODE == `PIO_MODE_BIDIR);

  // ---------------------------------------------------------------
  // Build checks
  // ---------------------------------------------------------------
  initial begin
    if (WIDTH < 1 || WIDTH > `PIO_MAX_WIDTH) begin
      $error("pio_port: WIDTH must be 1 to 32");
    end
    if (EDGE_KIND > `PIO_EDGE_ANY) begin
      $error("pio_port: bad EDGE_KIND");
    end
    if (!HAS_IN && (HAS_EDGE || HAS_IRQ)) begin
      $error("pio_port: edge or irq needs inputs");
    end
  end

  typedef struct packed {
    logic [WIDTH-1:0] out_val;
    logic [WIDTH-1:0] dir;
    logic [WIDTH-1:0] mask;
    logic [WIDTH-1:0] edge_lat;
    logic [WIDTH-1:0] prev;
    logic [`PIO_EV_W-1:0] istat;
    logic [`PIO_EV_W-1:0] imask;
    logic [31:0] rdata;
    logic [WIDTH-1:0] pin_out;
    logic [WIDTH-1:0] pin_oe;
    logic irq;
    logic ev_irq;
    logic prev_valid;
  } port_state_type;

  port_state_type s_q;
  port_state_type s_d;
  logic [WIDTH-1:0] in_sync;

  // Zero-extend a port-wide value to a bus word
  function automatic logic [31:0] widen(input logic [WIDTH-1:0] v);
    logic [31:0] w;
    w = '0;
    w[WIDTH-1:0] = v;
    return w;
  endfunction

  // Edge qualifier for one sample pair, fixed kind
  function automatic logic [WIDTH-1:0] edges(
      input logic [WIDTH-1:0] now, input logic [WIDTH-1:0] old);
    logic [WIDTH-1:0] e;
    case (EDGE_KIND)
      `PIO_EDGE_RISE: e = now & ~old;
      `PIO_EDGE_FALL: e = ~now & old;
      default: e = now ^ old;
    endcase
    return e;
  endfunction

  // ---------------------------------------------------------------
  // Pin sampling
  // ---------------------------------------------------------------
  pio_sync #(
    .WIDTH(WIDTH)
  ) u_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .async_in(port_in),
    .sync_out(in_sync)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [WIDTH-1:0] seen;
    logic [WIDTH-1:0] cond;
    logic [`PIO_EV_W-1:0] ev;
    logic req;
    seen = '0;
    cond = '0;
    ev = '0;
    req = 1'b0;
    s_d = s_q;
    // Sample history for edge compare
    s_d.prev = in_sync;
    s_d.prev_valid = 1'b1;
    if (HAS_EDGE && s_q.prev_valid) begin
      seen = edges(in_sync, s_q.prev);
    end
    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        `PIO_OFS_DATA: if (HAS_OUT) s_d.out_val = reg_wdata[WIDTH-1:0];
        `PIO_OFS_DIR: if (BIDIR) s_d.dir = reg_wdata[WIDTH-1:0];
        `PIO_OFS_MASK: if (HAS_IRQ) s_d.mask = reg_wdata[WIDTH-1:0];
        `PIO_OFS_EDGE: s_d.edge_lat = '0;
        `PIO_OFS_ISTAT: s_d.istat = s_q.istat & ~reg_wdata[`PIO_EV_W-1:0];
        `PIO_OFS_IMASK: s_d.imask = reg_wdata[`PIO_EV_W-1:0];
        default: s_d.imask = s_q.imask;
      endcase
    end
    // New edges win over a same-cycle clear
    s_d.edge_lat = s_d.edge_lat | seen;
    // Per-bit interrupt conditions
    if (HAS_IRQ) begin
      cond = (IRQ_EDGE ? s_q.edge_lat : in_sync) & s_q.mask;
    end
    req = |cond;
    // Sticky block events, set wins over clear
    ev[`PIO_EV_EDGE] = |seen;
    ev[`PIO_EV_IRQ] = req & ~s_q.irq;
    s_d.istat = s_d.istat | ev;
    s_d.irq = req;
    s_d.ev_irq = |(s_d.istat & s_q.imask);
    // Pin drivers
    if (BIDIR) begin
      s_d.pin_oe = s_d.dir;
      s_d.pin_out = s_d.out_val & s_d.dir;
    end else if (HAS_OUT) begin
      s_d.pin_oe = '1;
      s_d.pin_out = s_d.out_val;
    end else begin
      s_d.pin_oe = '0;
      s_d.pin_out = '0;
    end
    // Read data, valid the cycle after the strobe
    s_d.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        `PIO_OFS_DATA: if (HAS_IN) s_d.rdata = widen(in_sync);
        `PIO_OFS_DIR: s_d.rdata = widen(s_q.dir);
        `PIO_OFS_MASK: s_d.rdata = widen(s_q.mask);
        `PIO_OFS_EDGE: s_d.rdata = widen(s_q.edge_lat);
        `PIO_OFS_ISTAT: s_d.rdata = {{(32-`PIO_EV_W){1'b0}}, s_q.istat};
        `PIO_OFS_IMASK: s_d.rdata = {{(32-`PIO_EV_W){1'b0}}, s_q.imask};
        default: s_d.rdata = '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
      s_q.out_val <= OUT_RESET[WIDTH-1:0];
      s_q.pin_out <= BIDIR ? '0 : OUT_RESET[WIDTH-1:0];
      s_q.pin_oe <= (HAS_OUT && !BIDIR) ? '1 : '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign port_out = s_q.pin_out;
  assign port_oe = s_q.pin_oe;
  assign irq = s_q.irq;
  assign event_irq = s_q.ev_irq;
endmodule
`default_nettype wire

//--- hdl/pio_sync.sv
// Purpose: Two-stage synchroniser for the input pins
// Assumes: Single clock ref_clk, asynchronous high reset
// Notes: First stage is read by the second stage only
`default_nettype none
module pio_sync #(
  parameter int WIDTH = 32
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_type;
  sync_state_type s_q;
  sync_state_type s_d;

  // Shift the pin levels through two stages
  always_comb begin
    s_d = s_q;
    s_d.meta = async_in;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.stable;
endmodule
`default_nettype wire

//--- pkg/pio_defines.svh
// Purpose: Register offsets, reset values and encodings of the parallel port
// Assumes: Word offsets on the plain register port
// Notes: Definitions only
`ifndef PIO_DEFINES_SVH
`define PIO_DEFINES_SVH
`define PIO_ADDR_W 3
`define PIO_OFS_DATA 3'h0
`define PIO_OFS_DIR 3'h1
`define PIO_OFS_MASK 3'h2
`define PIO_OFS_EDGE 3'h3
`define PIO_OFS_ISTAT 3'h4
`define PIO_OFS_IMASK 3'h5
`define PIO_OUT_RESET 32'h0000_0000
`define PIO_MAX_WIDTH 32
`define PIO_MODE_IN 2'h0
`define PIO_MODE_OUT 2'h1
`define PIO_MODE_INOUT 2'h2
`define PIO_MODE_BIDIR 2'h3
`define PIO_EDGE_RISE 2'h0
`define PIO_EDGE_FALL 2'h1
`define PIO_EDGE_ANY 2'h2
`define PIO_EV_EDGE 0
`define PIO_EV_IRQ 1
`define PIO_EV_W 2
`endif

//--- pkg/pio_pkg.sv
// Purpose: Types shared by the parallel port files
// Assumes: pio_defines.svh holds the numbers
// Notes: Types only
`default_nettype none
package pio_pkg;
  typedef logic [1:0] port_mode_type;
  typedef logic [1:0] edge_kind_type;
endpackage
`default_nettype wire

//--- verif/parallel_io_port_with_edge_irq_bench.sv
// Purpose: Bus level tests of pio_port
// Assumes: 8 bit inout build, rising edges, edge irq
// Notes: Expected values worked out by hand
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("ERROR %0t got %0h exp %0h", $time, a, e); end end
module parallel_io_port_with_edge_irq_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'h0, reset = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
  logic irq, event_irq;
  logic [2:0] reg_addr = 3'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [7:0] level = 8'h0, port_in, port_out, port_oe;
  int checks = 0, n_mismatch = 0;
  always #20 ref_clk = ~ref_clk;
  pio_port #(.WIDTH(8)) DUT (.ref_clk(ref_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_in(port_in),
    .port_out(port_out), .port_oe(port_oe), .irq(irq), .event_irq(event_irq));
  pio_pin_model #(.WIDTH(8)) u_pins (.ref_clk(ref_clk), .level(level),
    .port_in(port_in));
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'h1;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_addr <= a; reg_rd <= 1'h1;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    #1 `CHK(reg_rdata, e)
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------
  // Test sequence
  // ----------------------------------
  initial begin
    repeat (16) @(posedge ref_clk);
    reset <= 1'h0;
    level <= 8'h3C;
    wr(3'h0, 32'hC3);
    #1 `CHK(port_out, 8'hC3)
    tick(4);
    rd(3'h0, 32'h3C);
    wr(3'h1, 32'h0);
    #1 `CHK(port_oe, 8'hFF)
    rd(3'h7, 32'h0);
    rd(3'h3, 32'h3C);
    wr(3'h3, 32'h0);
    rd(3'h3, 32'h0);
    $display("test data done");
    wr(3'h2, 32'h1);
    level <= 8'h3D;
    tick(6); `CHK(irq, 1'h1)
    level <= 8'h3C;
    tick(6); `CHK(irq, 1'h1)
    wr(3'h3, 32'h0);
    tick(2); `CHK(irq, 1'h0)
    level <= 8'h3E;
    tick(6); `CHK(irq, 1'h0)
    $display("test edge done");
    wr(3'h3, 32'h0);
    rd(3'h4, 32'h3);
    wr(3'h5, 32'h1);
    tick(2); `CHK(event_irq, 1'h1)
    wr(3'h4, 32'h3);
    tick(2); `CHK(event_irq, 1'h0)
    $display("test status done");
    wrap_up();
  end
  // Watchdog
  initial begin
    repeat (3000) @(posedge ref_clk);
    n_mismatch++;
    wrap_up();
  end
endmodule
`default_nettype wire

//--- verif/pio_pin_model.sv
// Purpose: User logic driving the input pins
// Assumes: Levels change just after a clock edge
// Notes: No release, pins always driven
`default_nettype none
module pio_pin_model #(parameter int WIDTH = 8) (
  input wire logic ref_clk,
  input wire logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] port_in
);
  initial port_in = '0;
  // Follow requested level after each edge
  always @(posedge ref_clk) port_in <= level;
endmodule
`default_nettype wire

//--- verif/pio_port_monitor.sv
// Purpose: Assertions on pio_port bus and pins
// Assumes: Inout build, rising edges, edge irq
// Notes: Mask kept as a shadow of bus writes
`default_nettype none
module pio_port_monitor #(parameter int WIDTH = 8) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [2:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [WIDTH-1:0] port_in,
  input wire logic [WIDTH-1:0] port_out,
  input wire logic [WIDTH-1:0] port_oe,
  input wire logic irq,
  input wire logic event_irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic [WIDTH-1:0] mask_q, wlow;
  logic clr;
  // Mask or edge latch write
  assign wlow = reg_wdata[WIDTH-1:0];
  assign clr = reg_wr && (reg_addr == 3'h2 || reg_addr == 3'h3);
  // Mask shadow
  always_ff @(posedge ref_clk or posedge reset)
    if (reset) mask_q <= '0;
    else if (reg_wr && reg_addr == 3'h2) mask_q <= wlow;
  chk_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero when idle");
  chk_data_read: assert property ($stable(port_in) [*4] ##0 reg_rd
    && reg_addr == 3'h0 |=> reg_rdata[WIDTH-1:0] == $past(port_in))
    else $error("data read differs from pins");
  chk_data_write: assert property (reg_wr && reg_addr == 3'h0
    |=> port_out == $past(wlow)) else $error("output not written");
  chk_oe_fixed: assert property (port_oe == '1)
    else $error("output enable dropped");
  chk_edge_irq: assert property ($rose(port_in[0]) && mask_q[0]
    |-> ##[2:5] irq) else $error("edge raised no irq");
  chk_mask_block: assert property ((mask_q == '0) [*2] |-> !irq)
    else $error("irq with mask clear");
  chk_edge_clear: assert property ($stable(port_in) [*4] ##0
    (reg_wr && reg_addr == 3'h3) ##1 $stable(port_in) |=> !irq)
    else $error("irq after latch clear");
  chk_latch_hold: assert property (irq && !clr && !$past(clr) |=> irq)
    else $error("irq dropped by itself");
  cover property (reg_rd && reg_addr == 3'h0);
  cover property ($rose(irq));
  cover property ($rose(event_irq));
endmodule
bind pio_port pio_port_monitor #(.WIDTH(WIDTH)) u_mon (.ref_clk(ref_clk),
  .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_in(port_in),
  .port_out(port_out), .port_oe(port_oe), .irq(irq), .event_irq(event_irq));
`default_nettype wire
